//--- rtcal_core.sv
// Functional notes
// - alarm minute keeps value over reset; binary 00h-3Bh or decimal tens 0-5.
// - alarm hour keeps value over reset; binary 00h-17h or decimal tens 0-2.
// - alarm weekday 1 to 7 in low nibble, kept by reset; high nibble zero.
// - weekday set-point writable only while the counter is unlocked.
// - field enables cleared by reset; high nibble read-only zero, low nibble writable.
// - enable bit 3 weekday, 2 hours, 1 minutes, 0 seconds.
// - reading control clears the alarm flag and its interrupt.
// - flag evaluated on each count advance and when the lock closes.
// - any control write clears the tick prescaler.
// - woke bit set by alarm wake, survives reset, cleared by control read.
// - decimal bit selects decimal counting and decimal set-points, else binary.
// - source 0: oscillator on, divide by 32768; source 1: oscillator off, mains input.
// - in mains mode rate bit 0 means 60 Hz, 1 means 50 Hz.
// - summer time bit is plain storage with no effect.
// - unlock 0: counter runs, counts protected; unlock 1: counts writable, counter stops.
// - interrupt only when enable bit 6 and alarm flag are both set.
// - reset clears interrupt enable and unlock, leaves other control bits.
// - alarm second keeps value over reset; binary 00h-3Bh or decimal tens 0-5.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module rtcal_core #(
   parameter int ADDR_W = 12,
   parameter int XTAL_DIV = rtcal_pkg::XTAL_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic tick_i,
   input wire logic time_step_i,
   input wire logic [7:0] cur_sec_i,
   input wire logic [7:0] cur_min_i,
   input wire logic [7:0] cur_hour_i,
   input wire logic [3:0] cur_dow_i,
   input wire logic sleep_i,
   output logic second_o,
   output logic count_run_o,
   output logic count_write_ok_o,
   output logic bcd_mode_o,
   output logic osc_en_o,
   output logic alarm_irq_o,
   output logic wake_o
);
   localparam logic [15:0] XTAL_LAST = 16'(XTAL_DIV - 1);

   typedef struct packed {
      logic [7:0] alarm_second_value;
      logic [7:0] alarm_minute_value;
      logic [7:0] ahour;
      logic [3:0] alarm_weekday_value;
      logic [3:0] aen;
      logic [7:0] ctrl;
      logic [15:0] pre;
      logic [2:0] tsync;
      logic ack;
      logic [7:0] rdat;
      logic wake;
      logic sec_pulse;
   } rtcal_state_s;

   rtcal_state_s s_q;
   rtcal_state_s s_d;
   logic req;
   logic wr;
   logic rd;
   logic tick_edge;
   logic match;
   logic lock_close;
   logic eval;
   logic set_flag;
   logic [15:0] pre_last;

   function automatic logic hit(input logic [7:0] idx);
      return adr_i[ADDR_W-1:2] == (ADDR_W-2)'(idx);
   endfunction

   // range check in the active coding
   function automatic logic fits(input logic [7:0] v, input logic [7:0] bin_max,
                                 input logic [3:0] tens_max, input logic bcd);
      if (bcd) begin
         return (v[7:4] <= tens_max) && (v[3:0] <= rtcal_pkg::BCD_ONES_MAX);
      end
      return v <= bin_max;
   endfunction

   assign req = cyc_i && stb_i;
   assign wr = req && we_i && s_q.ack && sel_i[0];
   assign rd = req && !we_i && s_q.ack;
   assign tick_edge = s_q.tsync[1] && !s_q.tsync[2];
   assign lock_close = wr && hit(rtcal_pkg::IDX_CTRL) && s_q.ctrl[rtcal_pkg::CTRL_UNLOCK]
                       && !dat_i[rtcal_pkg::CTRL_UNLOCK];
   assign eval = time_step_i || lock_close;
   // equal codings compare directly, so the match holds in binary and decimal
   assign match = (s_q.aen != rtcal_pkg::NIBBLE_ZERO)
      && (!s_q.aen[rtcal_pkg::EN_SEC] || s_q.alarm_second_value == cur_sec_i)
      && (!s_q.aen[rtcal_pkg::EN_MIN] || s_q.alarm_minute_value == cur_min_i)
      && (!s_q.aen[rtcal_pkg::EN_HOUR] || s_q.ahour == cur_hour_i)
      && (!s_q.aen[rtcal_pkg::EN_DOW] || s_q.alarm_weekday_value == cur_dow_i);
   assign set_flag = eval && match;
   assign pre_last = !s_q.ctrl[rtcal_pkg::CTRL_SRC] ? XTAL_LAST
                   : (s_q.ctrl[rtcal_pkg::CTRL_MAINS] ? rtcal_pkg::MAINS50_LAST
                                                      : rtcal_pkg::MAINS60_LAST);

   always_comb begin
      s_d = s_q;
      s_d.ack = req && !s_q.ack;
      s_d.wake = 1'b0;
      s_d.sec_pulse = 1'b0;
      s_d.tsync = {s_q.tsync[1:0], tick_i};
      // read data is prepared in the request cycle and shown with ack
      if (hit(rtcal_pkg::IDX_ALM_SEC)) begin
         s_d.rdat = s_q.alarm_second_value;
      end else if (hit(rtcal_pkg::IDX_ALM_MIN)) begin
         s_d.rdat = s_q.alarm_minute_value;
      end else if (hit(rtcal_pkg::IDX_AHOUR)) begin
         s_d.rdat = s_q.ahour;
      end else if (hit(rtcal_pkg::IDX_ALM_WEEKDAY)) begin
         s_d.rdat = {rtcal_pkg::NIBBLE_ZERO, s_q.alarm_weekday_value};
      end else if (hit(rtcal_pkg::IDX_AEN)) begin
         s_d.rdat = {rtcal_pkg::NIBBLE_ZERO, s_q.aen};
      end else if (hit(rtcal_pkg::IDX_CTRL)) begin
         s_d.rdat = s_q.ctrl;
      end else begin
         s_d.rdat = rtcal_pkg::BYTE_ZERO;
      end
      if (wr) begin
         if (hit(rtcal_pkg::IDX_ALM_SEC) && fits(dat_i[7:0], rtcal_pkg::MS_MAX_BIN,
             rtcal_pkg::MS_TENS_MAX, s_q.ctrl[rtcal_pkg::CTRL_BCD])) begin
            s_d.alarm_second_value = dat_i[7:0];
         end
         if (hit(rtcal_pkg::IDX_ALM_MIN) && fits(dat_i[7:0], rtcal_pkg::MS_MAX_BIN,
             rtcal_pkg::MS_TENS_MAX, s_q.ctrl[rtcal_pkg::CTRL_BCD])) begin
            s_d.alarm_minute_value = dat_i[7:0];
         end
         if (hit(rtcal_pkg::IDX_AHOUR) && fits(dat_i[7:0], rtcal_pkg::HOUR_MAX_BIN,
             rtcal_pkg::HOUR_TENS_MAX, s_q.ctrl[rtcal_pkg::CTRL_BCD])) begin
            s_d.ahour = dat_i[7:0];
         end
         if (hit(rtcal_pkg::IDX_ALM_WEEKDAY) && s_q.ctrl[rtcal_pkg::CTRL_UNLOCK]
             && dat_i[3:0] >= rtcal_pkg::DOW_MIN && dat_i[3:0] <= rtcal_pkg::DOW_MAX) begin
            s_d.alarm_weekday_value = dat_i[3:0];
         end
         if (hit(rtcal_pkg::IDX_AEN)) begin
            s_d.aen = dat_i[3:0];
         end
         if (hit(rtcal_pkg::IDX_CTRL)) begin
            // flag and woke bits are read-only and kept; summer time bit is plain storage
            s_d.ctrl[6:2] = dat_i[6:2];
            s_d.ctrl[rtcal_pkg::CTRL_UNLOCK] = dat_i[rtcal_pkg::CTRL_UNLOCK];
         end
      end
      // prescaler; the one-second pulse is held back while unlocked
      if (wr && hit(rtcal_pkg::IDX_CTRL)) begin
         s_d.pre = rtcal_pkg::PRE_ZERO;
      end else if (tick_edge) begin
         if (s_q.pre >= pre_last) begin
            s_d.pre = rtcal_pkg::PRE_ZERO;
            s_d.sec_pulse = !s_q.ctrl[rtcal_pkg::CTRL_UNLOCK];
         end else begin
            s_d.pre = s_q.pre + 16'h0001;
         end
      end
      // clear on read first, so a coincident alarm wins
      if (rd && hit(rtcal_pkg::IDX_CTRL)) begin
         s_d.ctrl[rtcal_pkg::CTRL_FLAG] = 1'b0;
         s_d.ctrl[rtcal_pkg::CTRL_WOKE] = 1'b0;
      end
      if (set_flag) begin
         s_d.ctrl[rtcal_pkg::CTRL_FLAG] = 1'b1;
         if (sleep_i) begin
            s_d.ctrl[rtcal_pkg::CTRL_WOKE] = 1'b1;
            s_d.wake = 1'b1;
         end
      end
      // system reset: set-points, flag, coding, source, rate, dst, woke survive
      if (rst_i) begin
         s_d.ctrl[rtcal_pkg::CTRL_IE] = 1'b0;
         s_d.ctrl[rtcal_pkg::CTRL_UNLOCK] = 1'b0;
         s_d.aen = rtcal_pkg::NIBBLE_ZERO;
         s_d.ack = 1'b0;
         s_d.wake = 1'b0;
         s_d.sec_pulse = 1'b0;
         s_d.pre = rtcal_pkg::PRE_ZERO;
      end
   end

   // power-on reset gives every bit a defined value
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = {rtcal_pkg::PAD_ZERO, s_q.rdat};
   assign ack_o = s_q.ack;
   assign second_o = s_q.sec_pulse;
   assign count_run_o = !s_q.ctrl[rtcal_pkg::CTRL_UNLOCK];
   assign count_write_ok_o = s_q.ctrl[rtcal_pkg::CTRL_UNLOCK];
   assign bcd_mode_o = s_q.ctrl[rtcal_pkg::CTRL_BCD];
   assign osc_en_o = !s_q.ctrl[rtcal_pkg::CTRL_SRC];
   assign alarm_irq_o = s_q.ctrl[rtcal_pkg::CTRL_FLAG] && s_q.ctrl[rtcal_pkg::CTRL_IE];
   assign wake_o = s_q.wake;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || por_i);

   sequence ctrl_read_s;
      rd && hit(rtcal_pkg::IDX_CTRL) && !set_flag;
   endsequence

   ack_one_cycle_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   flag_cause_a: assert property ($rose(s_q.ctrl[rtcal_pkg::CTRL_FLAG]) |-> $past(eval) && $past(match))
      else $error("alarm flag rose without an evaluated match");
   no_enable_a: assert property (s_q.aen == rtcal_pkg::NIBBLE_ZERO && !wr
                                 |=> !$rose(s_q.ctrl[rtcal_pkg::CTRL_FLAG]))
      else $error("alarm raised with no field enabled");
   flag_read_a: assert property (ctrl_read_s |=> !s_q.ctrl[rtcal_pkg::CTRL_FLAG] && !alarm_irq_o)
      else $error("control read did not clear the alarm");
   woke_read_a: assert property (ctrl_read_s |=> !s_q.ctrl[rtcal_pkg::CTRL_WOKE])
      else $error("control read did not clear woke bit");
   irq_gate_a: assert property (alarm_irq_o |-> s_q.ctrl[rtcal_pkg::CTRL_IE]
                                && s_q.ctrl[rtcal_pkg::CTRL_FLAG])
      else $error("interrupt without enable and flag");
   pre_clear_a: assert property (wr && hit(rtcal_pkg::IDX_CTRL) |=> s_q.pre == rtcal_pkg::PRE_ZERO)
      else $error("control write left prescaler running");
   dow_lock_a: assert property (wr && hit(rtcal_pkg::IDX_ALM_WEEKDAY)
                                && !s_q.ctrl[rtcal_pkg::CTRL_UNLOCK] |=> $stable(s_q.alarm_weekday_value))
      else $error("weekday written while locked");
   sec_stop_a: assert property (s_q.ctrl[rtcal_pkg::CTRL_UNLOCK] |=> !second_o)
      else $error("second pulse while unlocked");
   reset_ctrl_a: assert property (disable iff (por_i) rst_i |=> !s_q.ctrl[rtcal_pkg::CTRL_IE]
                                  && !s_q.ctrl[rtcal_pkg::CTRL_UNLOCK] && s_q.aen == rtcal_pkg::NIBBLE_ZERO)
      else $error("reset left enable or unlock set");

   sequence ctrl_write_s;
      wr && hit(rtcal_pkg::IDX_CTRL);
   endsequence

   sequence alarm_hit_s;
      eval && match;
   endsequence

   // bus handshake
   ack_answer_a: assert property (req && !ack_o |=> ack_o)
      else $error("request not answered in the next cycle");

   // set-point and field enable storage
   minute_store_a: assert property (wr && hit(rtcal_pkg::IDX_ALM_MIN)
                                    && fits(dat_i[7:0], rtcal_pkg::MS_MAX_BIN, rtcal_pkg::MS_TENS_MAX, bcd_mode_o)
                                    |=> s_q.alarm_minute_value == $past(dat_i[7:0]))
      else $error("valid minute set-point not stored");

   minute_range_a: assert property (wr && hit(rtcal_pkg::IDX_ALM_MIN)
                                    && !fits(dat_i[7:0], rtcal_pkg::MS_MAX_BIN, rtcal_pkg::MS_TENS_MAX, bcd_mode_o)
                                    |=> $stable(s_q.alarm_minute_value))
      else $error("out of range minute set-point stored");

   hour_range_a: assert property (wr && hit(rtcal_pkg::IDX_AHOUR)
                                  && !fits(dat_i[7:0], rtcal_pkg::HOUR_MAX_BIN, rtcal_pkg::HOUR_TENS_MAX, bcd_mode_o)
                                  |=> $stable(s_q.ahour))
      else $error("out of range hour set-point stored");

   hour_ones_a: assert property (wr && hit(rtcal_pkg::IDX_AHOUR) && bcd_mode_o
                                 && dat_i[3:0] > rtcal_pkg::BCD_ONES_MAX |=> $stable(s_q.ahour))
      else $error("decimal hour with bad ones digit stored");

   second_range_a: assert property (wr && hit(rtcal_pkg::IDX_ALM_SEC)
                                    && !fits(dat_i[7:0], rtcal_pkg::MS_MAX_BIN, rtcal_pkg::MS_TENS_MAX, bcd_mode_o)
                                    |=> $stable(s_q.alarm_second_value))
      else $error("out of range second set-point stored");

   weekday_range_a: assert property (wr && hit(rtcal_pkg::IDX_ALM_WEEKDAY)
                                     && dat_i[3:0] > rtcal_pkg::DOW_MAX |=> $stable(s_q.alarm_weekday_value))
      else $error("out of range weekday stored");

   weekday_read_a: assert property (ack_o && !we_i && hit(rtcal_pkg::IDX_ALM_WEEKDAY)
                                    |-> dat_o[7:4] == rtcal_pkg::NIBBLE_ZERO)
      else $error("weekday reserved bits read nonzero");

   enable_read_a: assert property (ack_o && !we_i && hit(rtcal_pkg::IDX_AEN)
                                   |-> dat_o[7:4] == rtcal_pkg::NIBBLE_ZERO)
      else $error("enable reserved bits read nonzero");

   enable_store_a: assert property (wr && hit(rtcal_pkg::IDX_AEN) |=> s_q.aen == $past(dat_i[3:0]))
      else $error("field enables not stored");

   setpoint_keep_a: assert property (disable iff (por_i) rst_i && !wr
                                     |=> $stable(s_q.alarm_second_value) && $stable(s_q.alarm_minute_value)
                                         && $stable(s_q.ahour) && $stable(s_q.alarm_weekday_value))
      else $error("set-point changed by system reset");

   // control register
   ctrl_keep_a: assert property (disable iff (por_i) rst_i && !wr && !rd && !set_flag
                                 |=> $stable(s_q.ctrl[rtcal_pkg::CTRL_FLAG])
                                     && $stable(s_q.ctrl[rtcal_pkg::CTRL_BCD:rtcal_pkg::CTRL_WOKE]))
      else $error("system reset changed a kept control bit");

   flag_set_a: assert property (alarm_hit_s |=> s_q.ctrl[rtcal_pkg::CTRL_FLAG])
      else $error("evaluated match did not set the flag");

   woke_set_a: assert property (alarm_hit_s ##0 sleep_i
                                |=> s_q.ctrl[rtcal_pkg::CTRL_WOKE] && wake_o)
      else $error("alarm in sleep did not set woke");

   ro_bits_a: assert property (ctrl_write_s |=> $past(set_flag)
                               || ($stable(s_q.ctrl[rtcal_pkg::CTRL_FLAG]) && $stable(s_q.ctrl[rtcal_pkg::CTRL_WOKE])))
      else $error("control write changed a read-only bit");

   dst_store_a: assert property (ctrl_write_s
                                 |=> s_q.ctrl[rtcal_pkg::CTRL_DST] == $past(dat_i[rtcal_pkg::CTRL_DST]))
      else $error("summer time bit not stored");

   unlock_store_a: assert property (ctrl_write_s
                                    |=> count_write_ok_o == $past(dat_i[rtcal_pkg::CTRL_UNLOCK]))
      else $error("unlock bit not stored");

   irq_follow_a: assert property (s_q.ctrl[rtcal_pkg::CTRL_FLAG] && s_q.ctrl[rtcal_pkg::CTRL_IE] |-> alarm_irq_o)
      else $error("enabled alarm without interrupt");

   // prescaler
   pre_count_a: assert property (tick_edge && s_q.pre < pre_last && !(wr && hit(rtcal_pkg::IDX_CTRL))
                                 |=> s_q.pre == 16'($past(s_q.pre) + 16'h0001) && !second_o)
      else $error("prescaler did not advance on a tick");

   pre_wrap_a: assert property (tick_edge && s_q.pre >= pre_last && !(wr && hit(rtcal_pkg::IDX_CTRL))
                                |=> s_q.pre == rtcal_pkg::PRE_ZERO
                                    && second_o == !$past(s_q.ctrl[rtcal_pkg::CTRL_UNLOCK]))
      else $error("prescaler did not wrap at its divisor");

   pulse_cause_a: assert property (second_o |-> $past(tick_edge))
      else $error("second pulse without a tick");
endmodule // rtcal_core
`default_nettype wire

//--- rtcal_pkg.sv
package rtcal_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_ALM_SEC = 8'he8;
   localparam logic [7:0] IDX_ALM_MIN = 8'he9;
   localparam logic [7:0] IDX_AHOUR = 8'hea;
   localparam logic [7:0] IDX_ALM_WEEKDAY = 8'heb;
   localparam logic [7:0] IDX_AEN = 8'hec;
   localparam logic [7:0] IDX_CTRL = 8'hed;
   // control register bit positions
   localparam int CTRL_FLAG = 7;
   localparam int CTRL_IE = 6;
   localparam int CTRL_BCD = 5;
   localparam int CTRL_SRC = 4;
   localparam int CTRL_MAINS = 3;
   localparam int CTRL_DST = 2;
   localparam int CTRL_WOKE = 1;
   localparam int CTRL_UNLOCK = 0;
   // enable register bit positions
   localparam int EN_DOW = 3;
   localparam int EN_HOUR = 2;
   localparam int EN_MIN = 1;
   localparam int EN_SEC = 0;
   // set-point ranges
   localparam logic [7:0] MS_MAX_BIN = 8'h3b;
   localparam logic [3:0] MS_TENS_MAX = 4'h5;
   localparam logic [7:0] HOUR_MAX_BIN = 8'h17;
   localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
   localparam logic [3:0] BCD_ONES_MAX = 4'h9;
   localparam logic [3:0] DOW_MIN = 4'h1;
   localparam logic [3:0] DOW_MAX = 4'h7;
   // prescaler: crystal divisor and last tick index of each mains rate
   localparam int XTAL_DIV = 32768;
   localparam logic [15:0] MAINS60_LAST = 16'h003b;
   localparam logic [15:0] MAINS50_LAST = 16'h0031;
   localparam logic [15:0] PRE_ZERO = 16'h0000;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [23:0] PAD_ZERO = 24'h00_0000;
endpackage

//--- tb_rtcal_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rtcal_core;
   logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic tick_i = 1'b0, time_step_i = 1'b0, sleep_i = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0] sel_i = 4'h0, cur_dow_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, seed = 32'h0000_75aa;
   logic [7:0] cur_sec_i = 8'h00, cur_min_i = 8'h00, cur_hour_i = 8'h00, rd, m_min, m_hour;
   logic ack_o, second_o, count_run_o, count_write_ok_o, bcd_mode_o, osc_en_o, alarm_irq_o, wake_o;
   int num_errors = 0, tests_run = 0, sec_cnt = 0, wake_cnt = 0;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (second_o === 1'b1) sec_cnt++;
      if (wake_o === 1'b1) wake_cnt++;
   end
   rtcal_core #(.XTAL_DIV(8)) rtcal_core_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tick_i(tick_i), .time_step_i(time_step_i), .cur_sec_i(cur_sec_i), .cur_min_i(cur_min_i),
      .cur_hour_i(cur_hour_i), .cur_dow_i(cur_dow_i), .sleep_i(sleep_i), .second_o(second_o),
      .count_run_o(count_run_o), .count_write_ok_o(count_write_ok_o), .bcd_mode_o(bcd_mode_o),
      .osc_en_o(osc_en_o), .alarm_irq_o(alarm_irq_o), .wake_o(wake_o));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {2'b00, idx, 2'b00};
      dat_i <= {24'h00_0000, wd};
      sel_i <= 4'h1;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o[7:0];
      // release only after the edge at which ack is sampled high
      @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         stop_test();
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(what, rd, exp);
   endtask
   // control write, then the level outputs follow the written bits
   task automatic wctl(input logic [7:0] v);
      bus(1'b1, rtcal_pkg::IDX_CTRL, v);
      @(negedge clk_i);
      chk("run", {7'h00, count_run_o}, {7'h00, ~v[0]});
      chk("write ok", {7'h00, count_write_ok_o}, {7'h00, v[0]});
      chk("bcd", {7'h00, bcd_mode_o}, {7'h00, v[5]});
      chk("osc", {7'h00, osc_en_o}, {7'h00, ~v[4]});
   endtask
   task automatic step();
      @(posedge clk_i);
      time_step_i <= 1'b1;
      @(posedge clk_i);
      time_step_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_i);
         tick_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         tick_i <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
   endtask
   initial begin
      repeat (50000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      por_i <= 1'b0;
      rst_i <= 1'b0;
      m_min = 8'(rnd() % 32'h0000_003c);
      m_hour = 8'(rnd() % 32'h0000_0018);
      bus(1'b1, rtcal_pkg::IDX_AEN, 8'hff);
      rdchk("enables", rtcal_pkg::IDX_AEN, 8'h0f);
      bus(1'b1, rtcal_pkg::IDX_ALM_MIN, m_min);
      bus(1'b1, rtcal_pkg::IDX_ALM_MIN, 8'h3c);
      rdchk("minute", rtcal_pkg::IDX_ALM_MIN, m_min);
      bus(1'b1, rtcal_pkg::IDX_AHOUR, m_hour);
      bus(1'b1, rtcal_pkg::IDX_AHOUR, 8'h18);
      rdchk("hour", rtcal_pkg::IDX_AHOUR, m_hour);
      bus(1'b1, rtcal_pkg::IDX_ALM_WEEKDAY, 8'h05);
      rdchk("weekday locked", rtcal_pkg::IDX_ALM_WEEKDAY, 8'h00);
      wctl(8'h01);
      bus(1'b1, rtcal_pkg::IDX_ALM_WEEKDAY, 8'h07);
      bus(1'b1, rtcal_pkg::IDX_ALM_WEEKDAY, 8'hf8);
      rdchk("weekday", rtcal_pkg::IDX_ALM_WEEKDAY, 8'h07);
      rdchk("unmapped", 8'hf0, 8'h00);
      wctl(8'h44);
      $display("test registers done");
      bus(1'b1, rtcal_pkg::IDX_AEN, 8'h02);
      @(posedge clk_i);
      cur_min_i <= m_min;
      cur_hour_i <= m_hour ^ 8'h01;
      sleep_i <= 1'b1;
      step();
      sleep_i <= 1'b0;
      chk("irq", {7'h00, alarm_irq_o}, 8'h01);
      chk("wake", 8'(wake_cnt), 8'h01);
      rdchk("control", rtcal_pkg::IDX_CTRL, 8'hc6);
      @(negedge clk_i);
      chk("irq clear", {7'h00, alarm_irq_o}, 8'h00);
      rdchk("control again", rtcal_pkg::IDX_CTRL, 8'h44);
      bus(1'b1, rtcal_pkg::IDX_AEN, 8'h00);
      step();
      rdchk("no enables", rtcal_pkg::IDX_CTRL, 8'h44);
      wctl(8'h04);
      bus(1'b1, rtcal_pkg::IDX_AEN, 8'h02);
      step();
      chk("irq masked", {7'h00, alarm_irq_o}, 8'h00);
      rdchk("flag only", rtcal_pkg::IDX_CTRL, 8'h84);
      $display("test alarm done");
      wctl(8'h65);
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("ctrl reset", rtcal_pkg::IDX_CTRL, 8'h24);
      rdchk("enables reset", rtcal_pkg::IDX_AEN, 8'h00);
      rdchk("minute kept", rtcal_pkg::IDX_ALM_MIN, m_min);
      rdchk("hour kept", rtcal_pkg::IDX_AHOUR, m_hour);
      rdchk("weekday kept", rtcal_pkg::IDX_ALM_WEEKDAY, 8'h07);
      $display("test reset done");
      wctl(8'h00);
      sec_cnt = 0;
      ticks(6);
      wctl(8'h00);
      ticks(6);
      chk("prescaler cleared", 8'(sec_cnt), 8'h00);
      ticks(2);
      chk("crystal second", 8'(sec_cnt), 8'h01);
      wctl(8'h18);
      ticks(50);
      chk("mains 50", 8'(sec_cnt), 8'h02);
      wctl(8'h10);
      ticks(59);
      chk("mains 60 early", 8'(sec_cnt), 8'h02);
      ticks(1);
      chk("mains 60", 8'(sec_cnt), 8'h03);
      $display("test prescaler done");
      stop_test();
   end
endmodule // tb_rtcal_core
`default_nettype wire
